// ===== usht_line.sv
// serial line partner: receive clock runs only inside frames, data lsb first
// assumes one caller at a time; 80 ns receive clock period
`timescale 1ns/1ps
module usht_line (
  output logic rxc_o,
  output logic rxd_o,
  output logic syn_o
);
  initial begin
    rxc_o = 1'b0;
    rxd_o = 1'b1;
    syn_o = 1'b0;
  end
  // data moves while the clock is low, taken at its rising edge
  task automatic send(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o = d[i];
      #40 rxc_o = 1'b1;
      #40 rxc_o = 1'b0;
    end
    rxd_o = ~rxd_o; // released line shows no stale bit
    #40; // gap keeps the next caller from moving the line in the same step
  endtask
  // sync held over a whole receive clock cycle, setup included
  task automatic sync_pulse();
    syn_o = 1'b1;
    #40 rxc_o = 1'b1;
    #40 rxc_o = 1'b0;
    #40 syn_o = 1'b0;
  endtask
endmodule

// ===== usht_pkg.sv
// constants, field layout and carrier types for the sync hunt / command / status block
// assumes an 8-bit cpu bus with command/data select and a 1x synchronous serial line
package usht_pkg;
  localparam int unsigned DW = 8;

  // mode word fields
  localparam int unsigned MODE_BAUD_LO = 0;
  localparam int unsigned MODE_LEN_LO  = 2;
  localparam int unsigned MODE_PEN     = 4;
  localparam int unsigned MODE_EVEN    = 5;
  localparam int unsigned MODE_EXTSYNC = 6;
  localparam int unsigned MODE_SINGLE  = 7;
  localparam logic [1:0]  BAUD_SYNC    = 2'h0;
  localparam logic [3:0]  CHAR_MIN     = 4'h5;
  localparam logic [3:0]  CHAR_MAX     = 4'h8;
  localparam logic [7:0]  MODE_RESET   = 8'h00;

  // command word fields
  localparam int unsigned CMD_TXEN  = 0;
  localparam int unsigned CMD_DTR   = 1;
  localparam int unsigned CMD_RXE   = 2;
  localparam int unsigned CMD_BREAK = 3;
  localparam int unsigned CMD_ECLR  = 4;
  localparam int unsigned CMD_RTS   = 5;
  localparam int unsigned CMD_IRST  = 6;
  localparam int unsigned CMD_HUNT  = 7;
  localparam logic [7:0]  CMD_RESET = 8'h00;

  // status word fields
  localparam int unsigned ST_TXRDY   = 0;
  localparam int unsigned ST_RXRDY   = 1;
  localparam int unsigned ST_TXEMPTY = 2;
  localparam int unsigned ST_PE      = 3;
  localparam int unsigned ST_OE      = 4;
  localparam int unsigned ST_FE      = 5;
  localparam int unsigned ST_SYNC_DETECT_FLAG  = 6;
  localparam int unsigned ST_DSR     = 7;

  // idle levels of the synchronised inputs
  localparam logic [11:0] BUS_IDLE  = 12'he00;
  localparam logic [4:0]  LINK_IDLE = 5'h0b;

  typedef struct packed {
    logic          cs_n;
    logic          rd_n;
    logic          wr_n;
    logic          cd;
    logic [DW-1:0] data;
  } usht_bus_s;

  typedef struct packed {
    logic rxc;
    logic rxd;
    logic syn;
    logic dsr_n;
    logic cts_n;
  } usht_link_s;

  typedef enum logic [1:0] {
    INIT_MODE,
    INIT_SYNC1,
    INIT_SYNC2,
    INIT_CMD
  } usht_init_e;

  typedef enum logic [2:0] {
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP,
    RX_HUNT,
    RX_HUNT2,
    RX_HPAR
  } usht_rx_e;
endpackage

// ===== usht_sva.sv
// port checker for usht_top: read answer timing, flag clearing, modem pins
// assumes host strobes of about 10 clocks; inputs pass 3-flop syncs
`timescale 1ns/1ps
module usht_sva (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cd_i,
  input wire logic cts_n_i,
  input wire logic tx_busy_i,
  input wire logic tx_line_i,
  input wire logic data_oe_o,
  input wire logic sync_detect_o,
  input wire logic sync_detect_oe_o,
  input wire logic serial_out_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic transmit_ready_o,
  input wire logic transmitter_empty_o
);
  logic [3:0] since_wr;
  // clocks since a write strobe, saturating; modem pins move only just after one
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      since_wr <= 4'hf;
    end else if (!wr_n_i) begin
      since_wr <= 4'h0;
    end else if (since_wr != 4'hf) begin
      since_wr <= since_wr + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // bus drive follows the read strobe within the sync latency
  property p_rda; $fell(rd_n_i) && !cs_n_i |-> ##[3:7] data_oe_o; endproperty
  a_rda: assert property (p_rda) else $error("read not answered");
  property p_rdr; $rose(rd_n_i) |-> ##[1:8] !data_oe_o; endproperty
  a_rdr: assert property (p_rdr) else $error("bus not released");
  property p_oec; $rose(data_oe_o) |-> !rd_n_i && !cs_n_i; endproperty
  a_oec: assert property (p_oec) else $error("bus driven without read");
  property p_syc;
    $fell(data_oe_o) && cd_i && sync_detect_oe_o |-> ##[0:3] !sync_detect_o;
  endproperty
  a_syc: assert property (p_syc) else $error("sync flag kept after status");
  property p_mdm; !$stable({rts_n_o, dtr_n_o}) |-> since_wr < 4'hc; endproperty
  a_mdm: assert property (p_mdm) else $error("modem pin moved alone");
  property p_lin; serial_out_o |-> $past(tx_line_i); endproperty
  a_lin: assert property (p_lin) else $error("serial out not from line");
  property p_emp; transmitter_empty_o |-> !$past(tx_busy_i); endproperty
  a_emp: assert property (p_emp) else $error("empty while busy");
  property p_cts; $rose(cts_n_i) |-> ##[1:8] !transmit_ready_o; endproperty
  a_cts: assert property (p_cts) else $error("ready without cts");
endmodule

// ===== usht_sync3.sv
// three-flop input synchroniser with agreement filter
// assumes inputs are asynchronous to clk_i; q_o moves only when stages two and three agree
`timescale 1ns/1ps
module usht_sync3 #(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  if (W < 1) begin : g_bad_width
    $error("usht_sync3: width must be at least one");
  end

  // first stage feeds only the second; filter looks at stages two and three
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      q_o    <= RST;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule

// ===== usht_top.sv
// sync hunt, command decode, status word and receive buffer of a serial interface
// assumes cpu strobes and the serial line are asynchronous to clk_i (100 MHz);
// the transmit shifter lives outside and hands its line level in on tx_line_i
`timescale 1ns/1ps
module usht_top
  import usht_pkg::*;
#(
  parameter int unsigned RX_DEPTH = 2
) (
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          cs_n_i,
  input  wire logic          rd_n_i,
  input  wire logic          wr_n_i,
  input  wire logic          cd_i,
  input  wire logic [DW-1:0] data_i,
  output logic      [DW-1:0] data_o,
  output logic               data_oe_o,
  input  wire logic          receive_clock_i,
  input  wire logic          serial_in_i,
  input  wire logic          sync_detect_i,
  output logic               sync_detect_o,
  output logic               sync_detect_oe_o,
  input  wire logic          dsr_n_i,
  input  wire logic          cts_n_i,
  output logic               serial_out_o,
  output logic               rts_n_o,
  output logic               dtr_n_o,
  output logic               receive_ready_o,
  output logic               transmit_ready_o,
  output logic               transmitter_empty_o,
  output logic      [DW-1:0] tx_data_o,
  output logic               tx_valid_o,
  input  wire logic          tx_taken_i,
  input  wire logic          tx_busy_i,
  input  wire logic          tx_line_i
);
  localparam int unsigned PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int unsigned CW = $clog2(RX_DEPTH + 1);

  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("usht_top: RX_DEPTH must be a power of two, at least 2");
  end

  usht_bus_s  bus;
  usht_link_s lk;
  logic       wr_prev_reg;
  logic       rd_prev_reg;
  logic       rxc_prev_reg;
  logic       wr_act_reg;
  logic       rd_act_reg;
  logic       rd_cd_reg;
  usht_init_e init_reg;
  logic [7:0] mode_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] command_reg;
  logic       hunt_pulse_reg;
  logic       eclr_pulse_reg;
  logic       irst_pulse_reg;
  usht_rx_e   rx_state_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic [7:0] char_reg;
  logic       hunt2_reg;
  logic       push_reg;
  logic       pe_evt_reg;
  logic       fe_evt_reg;
  logic       syn_evt_reg;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [CW-1:0] fill_reg;
  logic       pe_flag_reg;
  logic       oe_flag_reg;
  logic       fe_flag_reg;
  logic       sync_detect_flag_flag_reg;

  // cpu strobes and data, then link pins, each through three flops
  usht_sync3 #(.W(12), .RST(BUS_IDLE)) u_bus_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({cs_n_i, rd_n_i, wr_n_i, cd_i, data_i}),
    .q_o       (bus)
  );
  usht_sync3 #(.W(5), .RST(LINK_IDLE)) u_link_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({receive_clock_i, serial_in_i, sync_detect_i, dsr_n_i, cts_n_i}),
    .q_o       (lk)
  );

  // decoded views of mode, command and strobes
  logic       sync_mode;
  logic       ext_sync;
  logic       pen;
  logic [3:0] len;
  logic [7:0] len_mask;
  logic       wr_end;
  logic       rd_end;
  logic       ctl_wr;
  logic       dat_wr;
  logic       rxc_rise;
  logic       soft_rst;
  logic       rx_run;
  logic       rxe;
  logic [7:0] shift_next;
  logic [7:0] cur_char;
  logic [7:0] sync1_m;
  logic [7:0] sync2_m;
  logic       par_bad;
  logic       fifo_full;
  logic       fifo_pop;
  logic       tx_empty;
  logic       sync_detect_flag_view;
  logic [7:0] status;

  assign sync_mode  = (mode_reg[MODE_BAUD_LO +: 2] == BAUD_SYNC);
  assign ext_sync   = sync_mode & mode_reg[MODE_EXTSYNC];
  assign pen        = mode_reg[MODE_PEN];
  assign len        = CHAR_MIN + {2'h0, mode_reg[MODE_LEN_LO +: 2]};
  assign len_mask   = 8'hff >> (CHAR_MAX - len);
  assign wr_end     = bus.wr_n & ~wr_prev_reg & wr_act_reg;
  assign rd_end     = bus.rd_n & ~rd_prev_reg & rd_act_reg;
  assign ctl_wr     = wr_end & bus.cd;
  assign dat_wr     = wr_end & ~bus.cd;
  assign rxc_rise   = lk.rxc & ~rxc_prev_reg;
  assign soft_rst   = irst_pulse_reg;
  assign rx_run     = (init_reg == INIT_CMD);
  assign rxe        = command_reg[CMD_RXE];
  // lsb arrives first; the right shift leaves upper bits zero for short characters
  assign shift_next = {lk.rxd, shift_reg[7:1]};
  assign cur_char   = shift_next >> (CHAR_MAX - len);
  assign sync1_m    = sync1_reg & len_mask;
  assign sync2_m    = sync2_reg & len_mask;
  assign par_bad    = (^{char_reg, lk.rxd}) == mode_reg[MODE_EVEN];
  assign fifo_full  = (fill_reg == CW'(RX_DEPTH));
  assign fifo_pop   = rd_end & ~rd_cd_reg & (fill_reg != '0);
  assign tx_empty   = ~tx_valid_o & ~tx_busy_i;
  assign sync_detect_flag_view = ext_sync ? lk.syn : sync_detect_flag_flag_reg;

  // status word assembled from the pin terms, except ST_TXRDY omits the CMD_TXEN and cts_n gating of transmit_ready_o
  always_comb begin
    status              = 8'h00;
    status[ST_TXRDY]    = ~tx_valid_o;
    status[ST_RXRDY]    = (fill_reg != '0) & rxe;
    status[ST_TXEMPTY]  = tx_empty;
    status[ST_PE]       = pe_flag_reg;
    status[ST_OE]       = oe_flag_reg;
    status[ST_FE]       = fe_flag_reg;
    status[ST_SYNC_DETECT_FLAG]   = sync_detect_flag_view;
    status[ST_DSR]      = ~lk.dsr_n;
  end

  // strobe tracking: select caught at the falling edge of each strobe, c/d caught there only for reads
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_prev_reg  <= 1'b1;
      rd_prev_reg  <= 1'b1;
      rxc_prev_reg <= 1'b0;
      wr_act_reg   <= 1'b0;
      rd_act_reg   <= 1'b0;
      rd_cd_reg    <= 1'b0;
    end else begin
      wr_prev_reg  <= bus.wr_n;
      rd_prev_reg  <= bus.rd_n;
      rxc_prev_reg <= lk.rxc;
      if (!bus.wr_n && wr_prev_reg) begin
        wr_act_reg <= ~bus.cs_n;
      end else if (bus.wr_n) begin
        wr_act_reg <= 1'b0;
      end
      if (!bus.rd_n && rd_prev_reg) begin
        rd_act_reg <= ~bus.cs_n;
        rd_cd_reg  <= bus.cd;
      end else if (bus.rd_n) begin
        rd_act_reg <= 1'b0;
      end
    end
  end

  // control word sequencing: mode, sync chars, then commands
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_reg       <= INIT_MODE;
      mode_reg       <= MODE_RESET;
      sync1_reg      <= 8'h00;
      sync2_reg      <= 8'h00;
      command_reg    <= CMD_RESET;
      hunt_pulse_reg <= 1'b0;
      eclr_pulse_reg <= 1'b0;
      irst_pulse_reg <= 1'b0;
    end else begin
      // one-shot bits act only as single-cycle pulses; their copies in command_reg go unused
      hunt_pulse_reg <= 1'b0;
      eclr_pulse_reg <= 1'b0;
      irst_pulse_reg <= 1'b0;
      if (soft_rst) begin
        init_reg    <= INIT_MODE;
        mode_reg    <= MODE_RESET;
        command_reg <= CMD_RESET;
      end else if (ctl_wr) begin
        case (init_reg)
          INIT_MODE: begin
            mode_reg <= bus.data;
            init_reg <= (bus.data[MODE_BAUD_LO +: 2] == BAUD_SYNC) ? INIT_SYNC1 : INIT_CMD;
          end
          INIT_SYNC1: begin
            sync1_reg <= bus.data;
            init_reg  <= mode_reg[MODE_SINGLE] ? INIT_CMD : INIT_SYNC2;
          end
          INIT_SYNC2: begin
            sync2_reg <= bus.data;
            init_reg  <= INIT_CMD;
          end
          INIT_CMD: begin
            command_reg    <= bus.data;
            hunt_pulse_reg <= bus.data[CMD_HUNT];
            eclr_pulse_reg <= bus.data[CMD_ECLR];
            irst_pulse_reg <= bus.data[CMD_IRST];
          end
          default: init_reg <= INIT_MODE;
        endcase
      end
    end
  end

  // receiver: runs on each rising receive clock once init reaches INIT_CMD, regardless of receive enable
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state_reg <= RX_DATA;
      shift_reg    <= 8'h00;
      cnt_reg      <= 4'h0;
      char_reg     <= 8'h00;
      hunt2_reg    <= 1'b0;
      push_reg     <= 1'b0;
      pe_evt_reg   <= 1'b0;
      fe_evt_reg   <= 1'b0;
      syn_evt_reg  <= 1'b0;
    end else begin
      push_reg    <= 1'b0;
      pe_evt_reg  <= 1'b0;
      fe_evt_reg  <= 1'b0;
      syn_evt_reg <= 1'b0;
      if (soft_rst || !rx_run) begin
        rx_state_reg <= sync_mode ? RX_DATA : RX_START;
        cnt_reg      <= 4'h0;
        hunt2_reg    <= 1'b0;
      end else if (hunt_pulse_reg && sync_mode) begin
        // a command without enter-hunt never reaches here
        rx_state_reg <= RX_HUNT;
        cnt_reg      <= 4'h0;
        hunt2_reg    <= 1'b0;
      end else if (rxc_rise) begin
        shift_reg <= shift_next;
        case (rx_state_reg)
          RX_HUNT: begin
            if (ext_sync) begin
              if (lk.syn) begin
                rx_state_reg <= RX_DATA;
                cnt_reg      <= 4'h0;
              end
            end else if (cur_char == sync1_m) begin
              cnt_reg <= 4'h0;
              if (pen) begin
                rx_state_reg <= RX_HPAR;
              end else if (mode_reg[MODE_SINGLE]) begin
                rx_state_reg <= RX_DATA;
                syn_evt_reg  <= 1'b1;
              end else begin
                rx_state_reg <= RX_HUNT2;
              end
            end
          end
          RX_HUNT2: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == len - 4'h1) begin
              cnt_reg <= 4'h0;
              if (cur_char != sync2_m) begin
                rx_state_reg <= RX_HUNT;
              end else if (pen) begin
                rx_state_reg <= RX_HPAR;
                hunt2_reg    <= 1'b1;
              end else begin
                rx_state_reg <= RX_DATA;
                syn_evt_reg  <= 1'b1;
              end
            end
          end
          RX_HPAR: begin
            // parity bit of a sync char during hunt is not checked
            if (!hunt2_reg && !mode_reg[MODE_SINGLE]) begin
              rx_state_reg <= RX_HUNT2;
            end else begin
              rx_state_reg <= RX_DATA;
              syn_evt_reg  <= 1'b1;
            end
            hunt2_reg <= 1'b0;
          end
          RX_START: begin
            if (!lk.rxd) begin
              rx_state_reg <= RX_DATA;
              cnt_reg      <= 4'h0;
            end
          end
          RX_DATA: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == len - 4'h1) begin
              cnt_reg  <= 4'h0;
              char_reg <= cur_char;
              if (pen) begin
                rx_state_reg <= RX_PAR;
              end else if (!sync_mode) begin
                rx_state_reg <= RX_STOP;
              end else begin
                push_reg    <= 1'b1;
                syn_evt_reg <= ~ext_sync & (cur_char == sync1_m);
              end
            end
          end
          RX_PAR: begin
            pe_evt_reg <= par_bad;
            if (!sync_mode) begin
              rx_state_reg <= RX_STOP;
            end else begin
              rx_state_reg <= RX_DATA;
              push_reg     <= 1'b1;
              syn_evt_reg  <= ~ext_sync & (char_reg == sync1_m);
            end
          end
          RX_STOP: begin
            fe_evt_reg   <= ~lk.rxd;
            push_reg     <= 1'b1;
            rx_state_reg <= RX_START;
          end
          default: rx_state_reg <= RX_DATA;
        endcase
      end
    end
  end

  // receive buffer: a full buffer refuses the new char rather than losing an old one
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      fill_reg <= '0;
    end else if (soft_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      fill_reg <= '0;
    end else begin
      if (push_reg && !fifo_full) begin
        rx_mem[wptr_reg] <= char_reg;
        wptr_reg         <= wptr_reg + PW'(1);
      end
      if (fifo_pop) begin
        rptr_reg <= rptr_reg + PW'(1);
      end
      if ((push_reg && !fifo_full) && !fifo_pop) begin
        fill_reg <= fill_reg + CW'(1);
      end else if (!(push_reg && !fifo_full) && fifo_pop) begin
        fill_reg <= fill_reg - CW'(1);
      end
    end
  end

  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pe_flag_reg     <= 1'b0;
      oe_flag_reg     <= 1'b0;
      fe_flag_reg     <= 1'b0;
      sync_detect_flag_flag_reg <= 1'b0;
    end else if (soft_rst) begin
      pe_flag_reg     <= 1'b0;
      oe_flag_reg     <= 1'b0;
      fe_flag_reg     <= 1'b0;
      sync_detect_flag_flag_reg <= 1'b0;
    end else begin
      // error checks always run; receive enable only gates the flag set
      pe_flag_reg <= (pe_flag_reg & ~eclr_pulse_reg) | (pe_evt_reg & rxe);
      oe_flag_reg <= (oe_flag_reg & ~eclr_pulse_reg)
                   | (push_reg & fifo_full & rxe);
      fe_flag_reg <= (fe_flag_reg & ~eclr_pulse_reg) | (fe_evt_reg & rxe);
      // status read clears sync detect but leaves the receiver state alone
      sync_detect_flag_flag_reg <= (sync_detect_flag_flag_reg & ~(rd_end & rd_cd_reg)) | syn_evt_reg;
    end
  end

  // transmit holding buffer handed to the external shifter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_data_o  <= 8'h00;
      tx_valid_o <= 1'b0;
    end else if (soft_rst) begin
      tx_valid_o <= 1'b0;
    end else if (dat_wr && !tx_valid_o) begin
      tx_data_o  <= bus.data & len_mask;
      tx_valid_o <= 1'b1;
    end else if (tx_taken_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // registered pins and read data
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o              <= 8'h00;
      data_oe_o           <= 1'b0;
      sync_detect_o       <= 1'b0;
      sync_detect_oe_o    <= 1'b0;
      serial_out_o        <= 1'b1;
      rts_n_o             <= 1'b1;
      dtr_n_o             <= 1'b1;
      receive_ready_o     <= 1'b0;
      transmit_ready_o    <= 1'b0;
      transmitter_empty_o <= 1'b1;
    end else begin
      // status follows live state for the whole read, no waiting
      data_o              <= rd_cd_reg ? status : rx_mem[rptr_reg];
      data_oe_o           <= rd_act_reg & ~bus.rd_n;
      sync_detect_o       <= sync_detect_flag_flag_reg;
      sync_detect_oe_o    <= sync_mode & ~ext_sync;
      serial_out_o        <= command_reg[CMD_BREAK] ? 1'b0 : tx_line_i;
      rts_n_o             <= ~command_reg[CMD_RTS];
      dtr_n_o             <= ~command_reg[CMD_DTR];
      receive_ready_o     <= status[ST_RXRDY];
      transmit_ready_o    <= ~tx_valid_o & command_reg[CMD_TXEN] & ~lk.cts_n;
      transmitter_empty_o <= tx_empty;
    end
  end
endmodule

// ===== usht_top_bench.sv
// bench for usht_top: cpu bus tasks plus serial line partner
// assumes usht_sva and usht_line compiled first
`timescale 1ns/1ps
module usht_top_bench;
  logic       clk_i = 1'b0;
  logic       rst_n, cs_n, rd_n, wr_n, cd, dsr_n, cts_n;
  logic [7:0] din, dout, v, txd;
  logic       oe, sdo, sdoe, so, rts_n, dtr_n, rxrdy, txrdy;
  logic       txk, txb, txl, txv, txe;
  wire        rxc, rxd, syn;
  int         err_count = 0;
  int         checked = 0;
  always #5 clk_i = ~clk_i;
  usht_line line_u (.rxc_o(rxc), .rxd_o(rxd), .syn_o(syn));
  usht_top dut_u (
    .clk_i(clk_i), .reset_n_i(rst_n), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .cd_i(cd), .data_i(din), .data_o(dout), .data_oe_o(oe), .receive_clock_i(rxc),
    .serial_in_i(rxd), .sync_detect_i(sdoe ? sdo : syn), .sync_detect_o(sdo),
    .sync_detect_oe_o(sdoe), .dsr_n_i(dsr_n), .cts_n_i(cts_n), .serial_out_o(so),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .receive_ready_o(rxrdy), .transmit_ready_o(txrdy),
    .transmitter_empty_o(txe), .tx_data_o(txd), .tx_valid_o(txv), .tx_taken_i(txk),
    .tx_busy_i(txb), .tx_line_i(txl));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe of 10 clocks; select and data held well past its release
  task automatic bus(input logic w, input logic c, input logic [7:0] d);
    cs_n = 1'b0;
    cd = c;
    din = d;
    @(negedge clk_i);
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (10) @(negedge clk_i);
    v = dout;
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge clk_i);
    cs_n = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask
  task automatic summarize();
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {rst_n, cs_n, rd_n, wr_n, cd} = 5'h0f;
    {din, dsr_n, cts_n} = 10'h000;
    {txk, txb, txl} = 3'h1;
    repeat (6) @(negedge clk_i);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(rts_n, 1'b1);
    bus(1'b1, 1'b1, 8'h0c);
    bus(1'b1, 1'b1, 8'h96);
    bus(1'b1, 1'b1, 8'h69);
    bus(1'b1, 1'b1, 8'ha5);
    chk({rts_n, dtr_n, sdoe, txrdy}, 4'h7);
    line_u.send(8'h96, 8);
    repeat (8) @(negedge clk_i);
    chk(sdo, 1'b0);
    line_u.send(8'h69, 8);
    repeat (8) @(negedge clk_i);
    chk(sdo, 1'b1);
    line_u.send(8'h3c, 8);
    repeat (8) @(negedge clk_i);
    bus(1'b0, 1'b1, 8'h00);
    chk(v, 8'hc7);
    chk({sdo, rxrdy}, 2'h1);
    bus(1'b0, 1'b0, 8'h00);
    chk(v, 8'h3c);
    bus(1'b1, 1'b1, 8'h25);
    line_u.send(8'h96, 8);
    line_u.send(8'h5a, 8);
    line_u.send(8'h11, 8);
    repeat (8) @(negedge clk_i);
    chk(sdo, 1'b1);
    bus(1'b0, 1'b1, 8'h00);
    chk(v, 8'hd7);
    bus(1'b1, 1'b1, 8'h35);
    bus(1'b0, 1'b1, 8'h00);
    chk(v, 8'h87);
    bus(1'b0, 1'b0, 8'h00);
    chk(v, 8'h96);
    bus(1'b0, 1'b0, 8'h00);
    chk(v, 8'h5a);
    bus(1'b1, 1'b1, 8'h2d);
    chk(so, 1'b0);
    bus(1'b1, 1'b1, 8'h25);
    chk(so, 1'b1);
    // shifter line level passes through while no break is set
    txl = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(so, 1'b0);
    txl = 1'b1;
    // data write fills the transmit buffer; a second write is refused
    bus(1'b1, 1'b0, 8'hc3);
    bus(1'b1, 1'b0, 8'h5a);
    chk(txd, 8'hc3);
    chk({txv, txe, txrdy}, 3'h4);
    bus(1'b0, 1'b1, 8'h00);
    chk(v, 8'h80);
    txk = 1'b1;
    txb = 1'b1;
    @(negedge clk_i);
    txk = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({txv, txe, txrdy}, 3'h1);
    txb = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(txe, 1'b1);
    cts_n = 1'b1;
    repeat (8) @(negedge clk_i);
    chk(txrdy, 1'b0);
    bus(1'b1, 1'b1, 8'h40);
    chk(rts_n, 1'b1);
    bus(1'b1, 1'b1, 8'hc0);
    bus(1'b1, 1'b1, 8'h15);
    bus(1'b1, 1'b1, 8'h84);
    chk(sdoe, 1'b0);
    line_u.sync_pulse();
    line_u.send(8'h0d, 5);
    repeat (8) @(negedge clk_i);
    bus(1'b0, 1'b0, 8'h00);
    chk(v, 8'h0d);
    // single sync with odd parity: flag waits for the unchecked parity bit
    bus(1'b1, 1'b1, 8'h40);
    bus(1'b1, 1'b1, 8'h9c);
    bus(1'b1, 1'b1, 8'h96);
    bus(1'b1, 1'b1, 8'h84);
    line_u.send(8'h96, 8);
    repeat (8) @(negedge clk_i);
    chk(sdo, 1'b0);
    line_u.send(8'h00, 1);
    repeat (8) @(negedge clk_i);
    chk(sdo, 1'b1);
    bus(1'b0, 1'b1, 8'h00);
    chk(v, 8'hc5);
    line_u.send(8'h3c, 8);
    line_u.send(8'h00, 1);
    repeat (8) @(negedge clk_i);
    bus(1'b0, 1'b1, 8'h00);
    chk(v, 8'h8f);
    summarize();
  end
  // run needs about 14 us; a hang is cut well after that
  initial begin
    #60000;
    err_count++;
    summarize();
  end
endmodule
bind usht_top usht_sva chk_u (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
  .cd_i(cd_i), .cts_n_i(cts_n_i), .tx_busy_i(tx_busy_i), .tx_line_i(tx_line_i),
  .data_oe_o(data_oe_o), .sync_detect_o(sync_detect_o), .sync_detect_oe_o(sync_detect_oe_o),
  .serial_out_o(serial_out_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
  .transmit_ready_o(transmit_ready_o), .transmitter_empty_o(transmitter_empty_o));
